// *** logic/dcwt_pkg.sv ***
package dcwt_pkg;
  localparam int unsigned WORD_W = 18;
  localparam int unsigned DEV_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [17:0] ADDR_RST = 18'h00000;
  localparam logic [17:0] WC_RST = 18'h00000;
  localparam logic [17:0] CMD_RST = 18'h00000;
  // Command word field positions
  localparam int unsigned CMD_GO_BIT = 0;
  localparam int unsigned CMD_DIR_BIT = 1;
  localparam int unsigned CMD_MULTI_BIT = 2;
  localparam int unsigned CMD_UNIT_LSB = 3;
  localparam int unsigned CMD_UNIT_W = 3;
  localparam int unsigned CMD_OP_LSB = 6;
  localparam int unsigned CMD_OP_W = 3;
  // Status word field positions
  localparam int unsigned ST_DONE_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_DIR_BIT = 2;
  localparam int unsigned ST_UNIT_LSB = 3;

  typedef struct packed {
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic wr;
  } dcwt_mem_req_t;

  typedef enum logic [1:0] {
    DCWT_IDLE,
    DCWT_REQ,
    DCWT_XFER,
    DCWT_DONE
  } dcwt_state_t;
endpackage : dcwt_pkg

// *** logic/dcwt_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcwt_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = cnt_q < (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage carries no reset; contents are only read while counted valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule : dcwt_fifo
`default_nettype wire

// *** logic/dcwt_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcwt_top #(
  parameter int unsigned WORD_W = dcwt_pkg::WORD_W,
  parameter int unsigned DEPTH = dcwt_pkg::FIFO_DEPTH,
  parameter logic [dcwt_pkg::DEV_W-1:0] DEV_NUM = 8'h2a // Arbitrary device number
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program-controlled loads
  input wire logic addr_load,
  input wire logic wc_load,
  input wire logic cmd_load,
  input wire logic [WORD_W-1:0] prog_data,
  input wire logic done_clr,
  input wire logic status_rd,
  output logic [WORD_W-1:0] status_word,
  output logic status_valid,
  output logic attn_req,
  // Priority chain (pin input and outputs)
  input wire logic enable_in,
  output logic enable_out,
  output logic [dcwt_pkg::DEV_W-1:0] dev_num_out,
  // Memory port
  output logic mem_valid,
  input wire logic mem_ready,
  output dcwt_pkg::dcwt_mem_req_t mem_req,
  input wire logic mem_rd_valid,
  input wire logic [WORD_W-1:0] mem_rd_data,
  // Peripheral stream, output direction
  output logic per_out_valid,
  input wire logic per_out_ready,
  output logic [WORD_W-1:0] per_out_data,
  // Peripheral stream, input direction
  input wire logic per_in_valid,
  output logic per_in_ready,
  input wire logic [WORD_W-1:0] per_in_data
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  dcwt_pkg::dcwt_state_t st_q, st_d;
  logic [WORD_W-1:0] addr_q, addr_d, wc_q, wc_d, cmd_q, cmd_d;
  logic done_q, done_d, en_s1_q, en_s2_q, rd_pend_q, rd_pend_d;
  logic [WORD_W-1:0] stat_q, stat_d;
  logic stat_v_q, stat_v_d;
  logic dir_in, word_done, wc_ovf, f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [WORD_W-1:0] f_in_data, f_out_data;
  // Input words taken, counted like the word count: a peripheral that offers
  // extra words cannot strand them in the buffer and stall the block
  logic [WORD_W-1:0] in_cnt_q, in_cnt_d;
  logic in_full_q, in_full_d, in_open;

  assign dir_in = cmd_q[dcwt_pkg::CMD_DIR_BIT];
  assign wc_ovf = &wc_q; // Next increment wraps to zero

  // ----------------------------------------------------------------
  // Data buffer: memory-to-peripheral or peripheral-to-memory
  // ----------------------------------------------------------------
  // Output: memory read data fills, peripheral drains
  // Input: peripheral fills, memory write drains
  assign in_open = dir_in && f_in_ready && !in_full_q &&
    (st_q == dcwt_pkg::DCWT_REQ || st_q == dcwt_pkg::DCWT_XFER);
  assign f_in_valid = dir_in ? (per_in_valid && in_open) : mem_rd_valid;
  assign f_in_data = dir_in ? per_in_data : mem_rd_data;
  assign per_in_ready = in_open;
  assign per_out_valid = !dir_in && f_out_valid;
  assign per_out_data = f_out_data;
  assign f_out_ready = dir_in ? (st_q == dcwt_pkg::DCWT_XFER && mem_ready) : per_out_ready;

  dcwt_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Reads wait for buffer room so returned data is never dropped
  assign mem_valid = st_q == dcwt_pkg::DCWT_XFER &&
    (dir_in ? f_out_valid : (f_in_ready && !rd_pend_q));
  // Reads carry zero data, so a stalled read request shows no moving field
  always_comb begin
    mem_req.addr = addr_q;
    mem_req.data = dir_in ? f_out_data : '0;
    mem_req.wr = dir_in;
  end
  assign word_done = mem_valid && mem_ready;

  // ----------------------------------------------------------------
  // Priority chain and device number
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      en_s1_q <= enable_in;
      en_s2_q <= en_s1_q;
    end
  end
  assign enable_out = en_s2_q && st_q != dcwt_pkg::DCWT_REQ && st_q != dcwt_pkg::DCWT_XFER;
  assign dev_num_out = (cmd_q[dcwt_pkg::CMD_MULTI_BIT] && st_q == dcwt_pkg::DCWT_XFER) ?
    DEV_NUM : '0;

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wc_d = wc_q;
    cmd_d = cmd_q;
    done_d = done_q;
    rd_pend_d = rd_pend_q;
    in_cnt_d = in_cnt_q;
    in_full_d = in_full_q;
    if (addr_load && st_q == dcwt_pkg::DCWT_IDLE) addr_d = prog_data;
    if (wc_load && st_q == dcwt_pkg::DCWT_IDLE) begin
      wc_d = prog_data;
      in_cnt_d = prog_data;
      in_full_d = 1'b0;
    end
    if (per_in_valid && in_open) begin
      in_cnt_d = in_cnt_q + 1'b1;
      if (&in_cnt_q) in_full_d = 1'b1;
    end
    if (cmd_load && st_q == dcwt_pkg::DCWT_IDLE) cmd_d = prog_data;
    if (!dir_in && word_done) rd_pend_d = 1'b1;
    if (mem_rd_valid) rd_pend_d = 1'b0;
    if (done_clr) done_d = 1'b0;
    case (st_q)
      dcwt_pkg::DCWT_IDLE: begin
        if (cmd_load && prog_data[dcwt_pkg::CMD_GO_BIT]) st_d = dcwt_pkg::DCWT_REQ;
      end
      dcwt_pkg::DCWT_REQ: begin
        if (en_s2_q) st_d = dcwt_pkg::DCWT_XFER;
      end
      dcwt_pkg::DCWT_XFER: begin
        if (word_done) begin
          addr_d = addr_q + 1'b1;
          wc_d = wc_q + 1'b1;
          if (wc_ovf) st_d = dcwt_pkg::DCWT_DONE;
        end
      end
      dcwt_pkg::DCWT_DONE: begin
        // Wait for the last read word to leave the buffer before flagging
        if (!rd_pend_q && !f_out_valid) begin
          done_d = 1'b1; // Set beats a same-cycle clear
          st_d = dcwt_pkg::DCWT_IDLE;
        end
      end
      default: st_d = dcwt_pkg::DCWT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= dcwt_pkg::DCWT_IDLE;
      addr_q <= dcwt_pkg::ADDR_RST;
      wc_q <= dcwt_pkg::WC_RST;
      cmd_q <= dcwt_pkg::CMD_RST;
      done_q <= 1'b0;
      rd_pend_q <= 1'b0;
      in_cnt_q <= dcwt_pkg::WC_RST;
      in_full_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wc_q <= wc_d;
      cmd_q <= cmd_d;
      done_q <= done_d;
      rd_pend_q <= rd_pend_d;
      in_cnt_q <= in_cnt_d;
      in_full_q <= in_full_d;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  assign attn_req = done_q;
  always_comb begin
    stat_d = stat_q;
    stat_v_d = 1'b0;
    if (status_rd) begin
      stat_d = '0;
      stat_d[dcwt_pkg::ST_DONE_BIT] = done_q;
      stat_d[dcwt_pkg::ST_BUSY_BIT] = st_q != dcwt_pkg::DCWT_IDLE;
      stat_d[dcwt_pkg::ST_DIR_BIT] = dir_in;
      stat_d[dcwt_pkg::ST_UNIT_LSB +: dcwt_pkg::CMD_UNIT_W] =
        cmd_q[dcwt_pkg::CMD_UNIT_LSB +: dcwt_pkg::CMD_UNIT_W];
      stat_v_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
      stat_v_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      stat_v_q <= stat_v_d;
    end
  end
  assign status_word = stat_q;
  assign status_valid = stat_v_q;
endmodule : dcwt_top
`default_nettype wire

// *** verification/dcwt_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcwt_checker #(
  parameter logic [dcwt_pkg::DEV_W-1:0] DEV_NUM = 8'h2a
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed ports
  input wire logic done_clr,
  input wire logic status_rd,
  input wire logic status_valid,
  input wire logic attn_req,
  input wire logic enable_out,
  input wire logic [dcwt_pkg::DEV_W-1:0] dev_num_out,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire dcwt_pkg::dcwt_mem_req_t mem_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_chain_held: assert property (mem_valid |-> !enable_out)
    else $error("enable passed on");
  a_req_stable: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("request moved");
  a_one_read: assert property (mem_valid && mem_ready && !mem_req.wr |=> !mem_valid)
    else $error("read too early");
  a_status_pulse: assert property (status_rd |=> status_valid)
    else $error("no status");
  a_status_quiet: assert property (!status_rd |=> !status_valid)
    else $error("stray status");
  a_done_sticky: assert property (attn_req && !done_clr && !$past(done_clr) |=> attn_req)
    else $error("done lost");
  a_done_clear: assert property (attn_req && done_clr |-> ##[1:2] !attn_req)
    else $error("done stuck");
  a_dev_number: assert property
    (dev_num_out != 8'h00 |-> dev_num_out == DEV_NUM && !enable_out)
    else $error("bad device number");
endmodule : dcwt_checker
`default_nettype wire

// *** verification/dcwt_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcwt_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // High holds mem_ready low on every other cycle
  input wire logic slow,
  // Memory port
  input wire logic mem_valid,
  output logic mem_ready,
  input wire dcwt_pkg::dcwt_mem_req_t mem_req,
  output logic mem_rd_valid,
  output logic [17:0] mem_rd_data
);
  logic [17:0] mem [64];
  logic [17:0] rd_q;
  logic tick_q;
  logic take;
  assign take = mem_valid && mem_ready;
  assign mem_ready = !slow || tick_q;
  // Idle read bus shows the inverse, never a stale copy
  assign mem_rd_data = mem_rd_valid ? rd_q : ~rd_q;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 18'h00100 + 18'(i);
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
      mem_rd_valid <= 1'b0;
      rd_q <= 18'h00000;
    end else begin
      tick_q <= !tick_q;
      mem_rd_valid <= take && !mem_req.wr;
      if (take && !mem_req.wr) rd_q <= mem[mem_req.addr[5:0]];
      if (take && mem_req.wr) mem[mem_req.addr[5:0]] <= mem_req.data;
    end
  end
endmodule : dcwt_mem_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rst, addr_load, wc_load, cmd_load, done_clr, status_rd, enable_in, slow;
  logic per_out_ready, per_in_valid, status_valid, attn_req, enable_out, mem_valid, mem_ready;
  logic mem_rd_valid, per_out_valid, per_in_ready;
  logic [17:0] prog_data, per_in_data, status_word, per_out_data, mem_rd_data;
  logic [7:0] dev_num_out;
  dcwt_pkg::dcwt_mem_req_t mem_req;
  int failures, compares, cycles, accepts;
  dcwt_top i_dcwt_top (.clk_sys(clk_sys), .rst(rst), .addr_load(addr_load), .wc_load(wc_load),
    .cmd_load(cmd_load), .prog_data(prog_data), .done_clr(done_clr), .status_rd(status_rd),
    .status_word(status_word), .status_valid(status_valid), .attn_req(attn_req),
    .enable_in(enable_in), .enable_out(enable_out), .dev_num_out(dev_num_out),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .per_out_valid(per_out_valid),
    .per_out_ready(per_out_ready), .per_out_data(per_out_data), .per_in_valid(per_in_valid),
    .per_in_ready(per_in_ready), .per_in_data(per_in_data));
  dcwt_mem_model i_dcwt_mem_model (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (mem_valid && mem_ready && !mem_req.wr) accepts++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic put(input logic [4:0] strobes, input logic [17:0] v);
    @(negedge clk_sys);
    {addr_load, wc_load, cmd_load, status_rd, done_clr} = strobes;
    prog_data = v;
    @(negedge clk_sys);
    {addr_load, wc_load, cmd_load, status_rd, done_clr} = 5'h00;
  endtask : put
  task automatic start(input logic [17:0] a, input int n, input logic [17:0] cmd);
    accepts = 0;
    put(5'h10, a);
    put(5'h08, -18'(n));
    put(5'h04, cmd);
  endtask : start
  task automatic finish_xfer(input logic [17:0] st);
    for (int i = 0; i < 2000 && attn_req !== 1'b1; i++) @(negedge clk_sys);
    check(18'(attn_req), 18'h00001);
    put(5'h02, 18'h00000);
    @(negedge clk_sys);
    check(18'(status_word[5:0]), st);
    put(5'h01, 18'h00000);
    @(negedge clk_sys);
    check(18'(attn_req), 18'h00000);
  endtask : finish_xfer
  task automatic out_xfer(input logic [17:0] a, input int n, input int stall);
    check(18'(enable_out), 18'h00001);
    enable_in = 1'b0;
    start(a, n, 18'h0002d);
    repeat (10) @(negedge clk_sys);
    check(18'(accepts), 18'h00000);
    enable_in = 1'b1;
    repeat (stall) @(negedge clk_sys);
    check(18'(enable_out), 18'h00000);
    if (stall > 0) check(18'(dev_num_out), 18'h0002a);
    if (stall > 0) check(18'(accepts), 18'h00010);
    per_out_ready = 1'b1;
    for (int i = 0; i < n; i++) begin
      while (per_out_valid !== 1'b1) @(negedge clk_sys);
      check(per_out_data, a + 18'h00100 + 18'(i));
      @(negedge clk_sys);
    end
    per_out_ready = 1'b0;
    check(18'(accepts), 18'(n));
    finish_xfer(18'h00029);
  endtask : out_xfer
  task automatic in_xfer(input logic [17:0] a, input int n);
    slow = 1'b1;
    start(a, n, 18'h0000b);
    per_in_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      per_in_data = 18'h2a000 + 18'(i);
      while (per_in_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    per_in_valid = 1'b0;
    per_in_data = ~per_in_data;
    finish_xfer(18'h0000d);
    for (int i = 0; i < n; i++) begin
      check(i_dcwt_mem_model.mem[6'(a) + 6'(i)], 18'h2a000 + 18'(i));
    end
    slow = 1'b0;
  endtask : in_xfer
  task automatic complete_run;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    {addr_load, wc_load, cmd_load, done_clr, status_rd, slow, per_in_valid, per_out_ready} = 8'h00;
    enable_in = 1'b1;
    prog_data = 18'h00000;
    per_in_data = 18'h00000;
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    out_xfer(18'h00004, 3, 0);
    out_xfer(18'h00010, 24, 60);
    in_xfer(18'h00030, 5);
    complete_run();
  end
endmodule : tb_top
bind dcwt_top dcwt_checker #(.DEV_NUM(DEV_NUM)) i_dcwt_checker (.clk_sys(clk_sys), .rst(rst),
  .done_clr(done_clr), .status_rd(status_rd), .status_valid(status_valid),
  .attn_req(attn_req), .enable_out(enable_out), .dev_num_out(dev_num_out),
  .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req));
`default_nettype wire
